/* File: src/cmhf_consts.vh */
// Constants for the cable MAC header framer.
// Assumes inclusion by bare name from the design file.
`ifndef CMHF_CONSTS_VH
`define CMHF_CONSTS_VH
// APB register byte offsets
`define CMHF_REG_CTRL 12'h000
`define CMHF_REG_TX_HDR 12'h004
`define CMHF_REG_TX_LEN 12'h008
`define CMHF_REG_TX_EXT 12'h00c
`define CMHF_REG_STATUS 12'h010
`define CMHF_REG_RX_HDR 12'h014
`define CMHF_REG_RX_EXT 12'h018
`define CMHF_REG_RX_TLV 12'h01c
`define CMHF_REG_COUNT 12'h020
// Frame-control byte fields
`define CMHF_FT_HI 7
`define CMHF_FT_LO 6
`define CMHF_TP_HI 5
`define CMHF_TP_LO 1
`define CMHF_EHP_BIT 0
// Frame type codes
`define CMHF_FT_PACKET 2'h0
`define CMHF_FT_CELL 2'h1
`define CMHF_FT_RSVD 2'h2
`define CMHF_FT_MAC 2'h3
// MAC-specific type parameters
`define CMHF_TP_REQUEST 5'h02
`define CMHF_TP_CONCAT 5'h1c
`define CMHF_TP_STUFF 5'h1f
// Limits and check-sequence
`define CMHF_EXT_MAX 8'hf0
`define CMHF_CRC_POLY 16'h1021
`define CMHF_CRC_INIT 16'hffff
`define CMHF_EXT_DEPTH 256
// Control register bits
`define CMHF_CTRL_TX_GO 0
`define CMHF_CTRL_RX_EN 1
`define CMHF_CTRL_EXT_RD 2
`define CMHF_CTRL_CLR_ERR 3
`define CMHF_CTRL_TLV_EN 4
`endif

/* File: src/cmhf_framer.v */
// Cable MAC header framer: upstream header builder with LSB-first
// serialiser, downstream octet-wide header parser, APB register file.
// Assumes one core clock; physical side gives a frame-start pulse
// and reads one bit per cycle; convergence side gives whole octets.
//
// Summary of operation
// RULE_01 - Upstream octets leave least significant bit first
// RULE_02 - Multi-octet values sent most significant octet first
// RULE_03 - Signed values held in two's complement
// RULE_04 - TLV type and length one byte each
// RULE_05 - Unknown TLV types skipped by length, no error
// RULE_06 - Header order: control, parameter, length, ext, check
// RULE_07 - Length equals extension plus trailing bytes
// RULE_08 - Request header carries service identifier in length
// RULE_09 - Check sequence covers control through extension
// RULE_10 - Check uses CCITT polynomial x16+x12+x5+1
// RULE_11 - Top two bits give frame type
// RULE_12 - Next five bits interpreted per frame type
// RULE_13 - Bit zero flags extended header present
// RULE_14 - Byte 0xff never sent as valid header
// RULE_15 - Parameter byte is extension length, max 240
// RULE_16 - Concatenation parameter counts concatenated frames
// RULE_17 - Request parameter gives mini-slots requested
// RULE_18 - Otherwise parameter byte treated as reserved
// RULE_19 - Received extension bytes passed to processor
// RULE_20 - Physical layer signals each upstream frame start
// RULE_21 - Downstream data arrives as whole octets
// RULE_22 - Reserved fields ignored on reception
// RULE_23 - Cell and reserved types skipped by length
// RULE_24 - Check mismatch discards frame, flags error
//
// Local design decisions: register access over APB and the register addresses.
`include "cmhf_consts.vh"
`timescale 1ns/1ns
`default_nettype none
module cmhf_framer (
   // Clock and reset
   input wire core_clk,
   input wire sys_rst,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Upstream physical side
   input wire us_frame_start,
   output reg us_bit,
   output reg us_bit_valid,
   output reg us_busy,
   // Downstream convergence side
   input wire [7:0] ds_octet,
   input wire ds_octet_valid,
   input wire ds_frame_start,
   // Received payload octets after a good header
   output reg [7:0] rx_payload,
   output reg rx_payload_valid
);
   // Parser states
   localparam [2:0] RS_IDLE = 3'h0;
   localparam [2:0] RS_HDR = 3'h1;
   localparam [2:0] RS_EXT = 3'h2;
   localparam [2:0] RS_HCS = 3'h3;
   localparam [2:0] RS_BODY = 3'h4;
   localparam [2:0] RS_SKIP = 3'h5;

   // CCITT step over one octet, MSB first within the check
   function [15:0] crc_byte;
      input [15:0] c;
      input [7:0] d;
      integer i;
      reg [15:0] r;
      begin
         r = c;
         for (i = 7; i >= 0; i = i - 1) begin
            if (r[15] ^ d[i])
               r = {r[14:0], 1'b0} ^ `CMHF_CRC_POLY; // RULE_10
            else
               r = {r[14:0], 1'b0};
         end
         crc_byte = r;
      end
   endfunction

   // Software-visible state
   reg [7:0] tx_ctl;
   reg [7:0] tx_parm;
   reg [15:0] tx_len;
   reg tx_go;
   reg rx_en;
   reg tlv_en;
   reg hdr_err;
   reg hdr_ok;
   reg stuff_err;
   reg [15:0] good_cnt;
   reg [15:0] bad_cnt;
   reg [7:0] rx_ctl;
   reg [7:0] rx_parm;
   reg [15:0] rx_len;
   reg [7:0] ext_wr_ptr;
   reg [7:0] ext_rd_ptr;
   reg [7:0] ext_len;
   reg [7:0] tx_ext_cnt;
   reg [7:0] tx_ext [0:`CMHF_EXT_DEPTH-1];
   reg [7:0] rx_ext [0:`CMHF_EXT_DEPTH-1];
   reg [7:0] tlv_unknown;
   reg [7:0] tlv_last;

   // Transmit serialiser state
   reg [8:0] tx_idx;
   reg [8:0] tx_total;
   reg [2:0] bit_idx;
   reg [7:0] tx_sr;
   reg [15:0] tx_crc;

   // Receive parser state
   reg [2:0] rs;
   reg [8:0] rx_cnt;
   reg [15:0] rx_crc;
   reg [15:0] rx_hcs;
   reg [15:0] body_left;
   reg [1:0] tlv_ph;
   reg [7:0] tlv_left;

   wire apb_wr = psel & penable & pwrite & ~pready;
   wire apb_rd = psel & penable & ~pwrite & ~pready;
   wire [1:0] rx_ft = rx_ctl[`CMHF_FT_HI:`CMHF_FT_LO];
   wire [4:0] rx_tp = rx_ctl[`CMHF_TP_HI:`CMHF_TP_LO];
   wire tx_ehp = tx_ctl[`CMHF_EHP_BIT];
   wire [7:0] tx_ext_header_length = tx_ehp ? tx_parm : 8'h00;
   wire tx_stuff = (tx_ctl[`CMHF_FT_HI:`CMHF_FT_LO] == `CMHF_FT_MAC) &&
      (tx_ctl[`CMHF_TP_HI:`CMHF_TP_LO] == `CMHF_TP_STUFF);

   // Octet of the outgoing header at position p
   function [7:0] tx_octet;
      input [8:0] p;
      begin
         if (p == 9'h000)
            tx_octet = tx_ctl;
         else if (p == 9'h001)
            tx_octet = tx_parm;
         else if (p == 9'h002)
            tx_octet = tx_len[15:8]; // RULE_02
         else if (p == 9'h003)
            tx_octet = tx_len[7:0];
         else if (p < {1'b0, tx_ext_header_length} + 9'h004)
            tx_octet = tx_ext[p[7:0] - 8'h04];
         else if (p == {1'b0, tx_ext_header_length} + 9'h004)
            tx_octet = ~tx_crc[15:8]; // RULE_09
         else
            tx_octet = ~tx_crc[7:0];
      end
   endfunction

   // APB slave: one-wait-state single access, error on unmapped offset
   always @(posedge core_clk) begin
      if (sys_rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         tx_ctl <= 8'h00;
         tx_parm <= 8'h00;
         tx_len <= 16'h0000;
         tx_ext_cnt <= 8'h00;
         rx_en <= 1'b0;
         tlv_en <= 1'b0;
         ext_rd_ptr <= 8'h00;
      end else begin
         pready <= apb_wr | apb_rd;
         pslverr <= 1'b0;
         if (apb_wr) begin
            case (paddr)
               `CMHF_REG_CTRL: begin
                  rx_en <= pwdata[`CMHF_CTRL_RX_EN];
                  tlv_en <= pwdata[`CMHF_CTRL_TLV_EN];
                  if (pwdata[`CMHF_CTRL_EXT_RD])
                     ext_rd_ptr <= 8'h00;
               end
               `CMHF_REG_TX_HDR: begin
                  tx_ctl <= pwdata[7:0];
                  tx_parm <= pwdata[15:8];
                  tx_ext_cnt <= 8'h00;
               end
               // Length, or service identifier for a request
               `CMHF_REG_TX_LEN: tx_len <= pwdata[15:0]; // RULE_07 RULE_08
               `CMHF_REG_TX_EXT: tx_ext_cnt <= tx_ext_cnt + 8'h01;
               `CMHF_REG_STATUS, `CMHF_REG_RX_HDR, `CMHF_REG_RX_EXT,
               `CMHF_REG_RX_TLV, `CMHF_REG_COUNT: ;
               default: pslverr <= 1'b1;
            endcase
         end else if (apb_rd) begin
            prdata <= 32'h00000000;
            case (paddr)
               `CMHF_REG_CTRL:
                  prdata <= {27'h0, tlv_en, 2'b00, rx_en, tx_go};
               `CMHF_REG_TX_HDR: prdata <= {16'h0, tx_parm, tx_ctl};
               `CMHF_REG_TX_LEN: prdata <= {16'h0, tx_len};
               `CMHF_REG_TX_EXT: prdata <= {24'h0, tx_ext_cnt};
               `CMHF_REG_STATUS:
                  prdata <= {16'h0, ext_len, 3'h0, rs == RS_IDLE,
                     stuff_err, us_busy, hdr_ok, hdr_err};
               `CMHF_REG_RX_HDR: prdata <= {rx_len, rx_parm, rx_ctl};
               `CMHF_REG_RX_EXT: begin
                  prdata <= {24'h0, rx_ext[ext_rd_ptr]}; // RULE_19
                  ext_rd_ptr <= ext_rd_ptr + 8'h01;
               end
               `CMHF_REG_RX_TLV: prdata <= {16'h0, tlv_last, tlv_unknown};
               `CMHF_REG_COUNT: prdata <= {bad_cnt, good_cnt};
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end

   // Transmit extension store, filled one byte per write
   always @(posedge core_clk) begin
      if (apb_wr && paddr == `CMHF_REG_TX_EXT)
         tx_ext[tx_ext_cnt] <= pwdata[7:0];
   end

   // Upstream builder: header octets out LSB first after frame start
   always @(posedge core_clk) begin
      if (sys_rst) begin
         tx_go <= 1'b0;
         us_busy <= 1'b0;
         us_bit <= 1'b0;
         us_bit_valid <= 1'b0;
         tx_idx <= 9'h000;
         tx_total <= 9'h000;
         bit_idx <= 3'h0;
         tx_sr <= 8'h00;
         tx_crc <= `CMHF_CRC_INIT;
         stuff_err <= 1'b0;
      end else begin
         us_bit_valid <= 1'b0;
         // Clear comes first so a refusal in the same write wins
         if (apb_wr && paddr == `CMHF_REG_CTRL &&
               pwdata[`CMHF_CTRL_CLR_ERR])
            stuff_err <= 1'b0;
         if (apb_wr && paddr == `CMHF_REG_CTRL &&
               pwdata[`CMHF_CTRL_TX_GO] && !us_busy) begin
            if (tx_stuff || (tx_ehp && tx_parm > `CMHF_EXT_MAX))
               stuff_err <= 1'b1; // RULE_14 RULE_15
            else
               tx_go <= 1'b1;
         end
         // Waits for the physical layer to open the frame
         if (tx_go && !us_busy && us_frame_start) begin // RULE_20
            us_busy <= 1'b1;
            tx_go <= 1'b0;
            tx_idx <= 9'h000;
            bit_idx <= 3'h0;
            tx_total <= {1'b0, tx_ext_header_length} + 9'h006; // RULE_06 RULE_13
            tx_sr <= tx_ctl;
            tx_crc <= crc_byte(`CMHF_CRC_INIT, tx_ctl);
         end else if (us_busy && tx_idx == tx_total) begin
            us_busy <= 1'b0; // Busy spans the last bit
         end else if (us_busy) begin
            us_bit <= tx_sr[bit_idx]; // RULE_01
            us_bit_valid <= 1'b1;
            bit_idx <= bit_idx + 3'h1;
            if (bit_idx == 3'h7) begin
               tx_idx <= tx_idx + 9'h001;
               tx_sr <= tx_octet(tx_idx + 9'h001);
               if (tx_idx + 9'h001 < {1'b0, tx_ext_header_length} + 9'h004)
                  tx_crc <= crc_byte(tx_crc, tx_octet(tx_idx + 9'h001));
            end
         end
      end
   end

   // Downstream parser on whole octets
   always @(posedge core_clk) begin
      if (sys_rst) begin
         rs <= RS_IDLE;
         rx_cnt <= 9'h000;
         rx_crc <= `CMHF_CRC_INIT;
         rx_hcs <= 16'h0000;
         rx_ctl <= 8'h00;
         rx_parm <= 8'h00;
         rx_len <= 16'h0000;
         ext_len <= 8'h00;
         ext_wr_ptr <= 8'h00;
         body_left <= 16'h0000;
         hdr_err <= 1'b0;
         hdr_ok <= 1'b0;
         good_cnt <= 16'h0000;
         bad_cnt <= 16'h0000;
         rx_payload <= 8'h00;
         rx_payload_valid <= 1'b0;
         tlv_ph <= 2'h0;
         tlv_left <= 8'h00;
         tlv_unknown <= 8'h00;
         tlv_last <= 8'h00;
      end else begin
         rx_payload_valid <= 1'b0;
         if (apb_wr && paddr == `CMHF_REG_CTRL &&
               pwdata[`CMHF_CTRL_CLR_ERR]) begin
            hdr_err <= 1'b0;
            hdr_ok <= 1'b0;
         end
         if (rx_en && ds_octet_valid) begin // RULE_21
            case (rs)
               RS_IDLE: begin
                  // Stuff bytes between frames are dropped
                  if (ds_frame_start && ds_octet != 8'hff) begin // RULE_14
                     rx_ctl <= ds_octet;
                     rx_crc <= crc_byte(`CMHF_CRC_INIT, ds_octet); // RULE_09
                     rx_cnt <= 9'h001;
                     rs <= RS_HDR;
                  end
               end
               RS_HDR: begin
                  rx_crc <= crc_byte(rx_crc, ds_octet);
                  rx_cnt <= rx_cnt + 9'h001;
                  if (rx_cnt == 9'h001) begin
                     rx_parm <= ds_octet; // RULE_16 RULE_17 RULE_18
                  end else if (rx_cnt == 9'h002) begin
                     rx_len[15:8] <= ds_octet; // RULE_02
                  end else begin
                     rx_len[7:0] <= ds_octet;
                     ext_wr_ptr <= 8'h00;
                     tlv_ph <= 2'h0;
                     ext_len <= rx_ctl[`CMHF_EHP_BIT] ? rx_parm : 8'h00;
                     // Extension only when flag set and length nonzero
                     if (rx_ctl[`CMHF_EHP_BIT] && rx_parm != 8'h00)
                        rs <= RS_EXT; // RULE_13 RULE_15
                     else
                        rs <= RS_HCS;
                     rx_cnt <= 9'h000;
                  end
               end
               RS_EXT: begin
                  rx_crc <= crc_byte(rx_crc, ds_octet);
                  ext_wr_ptr <= ext_wr_ptr + 8'h01;
                  // Walk TLV elements: type, length, value
                  if (tlv_en) begin
                     case (tlv_ph)
                        2'h0: begin
                           tlv_last <= ds_octet; // RULE_04
                           tlv_ph <= 2'h1;
                        end
                        2'h1: begin
                           tlv_left <= ds_octet;
                           // Zero length element has no value bytes
                           tlv_ph <= (ds_octet == 8'h00) ? 2'h0 : 2'h2;
                           if (tlv_last == 8'h00 || tlv_last > 8'h0f)
                              tlv_unknown <= tlv_unknown + 8'h01; // RULE_05
                        end
                        2'h2: begin
                           tlv_left <= tlv_left - 8'h01;
                           if (tlv_left == 8'h01)
                              tlv_ph <= 2'h0;
                        end
                        default: tlv_ph <= 2'h0;
                     endcase
                  end
                  if (ext_wr_ptr + 8'h01 == ext_len)
                     rs <= RS_HCS;
               end
               RS_HCS: begin
                  rx_cnt <= rx_cnt + 9'h001;
                  if (rx_cnt == 9'h000) begin
                     rx_hcs[15:8] <= ds_octet;
                  end else begin
                     // Payload length excludes extension bytes
                     body_left <= rx_len - {8'h00, ext_len}; // RULE_07
                     if ({rx_hcs[15:8], ds_octet} != ~rx_crc) begin
                        hdr_err <= 1'b1; // RULE_24
                        bad_cnt <= bad_cnt + 16'h0001;
                        rs <= RS_IDLE;
                     end else begin
                        hdr_ok <= 1'b1;
                        good_cnt <= good_cnt + 16'h0001;
                        if (rx_ft == `CMHF_FT_MAC &&
                              rx_tp == `CMHF_TP_REQUEST)
                           rs <= RS_IDLE; // RULE_08
                        else if (rx_len == {8'h00, ext_len})
                           rs <= RS_IDLE;
                        else if (rx_ft == `CMHF_FT_CELL ||
                              rx_ft == `CMHF_FT_RSVD)
                           rs <= RS_SKIP; // RULE_11 RULE_23
                        else
                           rs <= RS_BODY; // RULE_12 RULE_22
                     end
                  end
               end
               RS_BODY: begin
                  rx_payload <= ds_octet;
                  rx_payload_valid <= 1'b1;
                  body_left <= body_left - 16'h0001;
                  if (body_left == 16'h0001)
                     rs <= RS_IDLE;
               end
               RS_SKIP: begin
                  body_left <= body_left - 16'h0001;
                  if (body_left == 16'h0001)
                     rs <= RS_IDLE;
               end
               default: rs <= RS_IDLE;
            endcase
         end
      end
   end

   // Received extension store for software reads
   always @(posedge core_clk) begin
      if (rx_en && ds_octet_valid && rs == RS_EXT)
         rx_ext[ext_wr_ptr] <= ds_octet; // RULE_19
   end
   // Signed fields pass through as raw two's complement bits. RULE_03
endmodule // cmhf_framer
`default_nettype wire

/* File: tb/cmhf_framer_monitor.sv */
// Port checker for the header framer: serial header shape and echo.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module cmhf_framer_monitor (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Upstream serial side
   input wire logic us_bit,
   input wire logic us_bit_valid,
   input wire logic us_busy,
   // Downstream octets and payload
   input wire logic [7:0] ds_octet,
   input wire logic ds_octet_valid,
   input wire logic [7:0] rx_payload,
   input wire logic rx_payload_valid
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   logic [11:0] nbits;
   logic [7:0] shreg;
   logic [7:0] ctl_q;
   logic [7:0] parm_q;
   wire [11:0] ext_bits = ctl_q[0] ? {1'b0, parm_q, 3'b000} : 12'h000;
   // Bits of the current header; cleared whenever the shifter is idle
   always @(posedge core_clk) begin
      if (sys_rst || !us_busy) begin
         nbits <= 12'h000;
      end else if (us_bit_valid) begin
         nbits <= nbits + 12'h001;
      end
   end
   // Rebuild the first two octets LSB first; no reset needed, read late
   always @(posedge core_clk) begin
      if (us_bit_valid) begin
         shreg <= {us_bit, shreg[7:1]};
         if (nbits == 12'h007) ctl_q <= {us_bit, shreg[7:1]};
         if (nbits == 12'h00f) parm_q <= {us_bit, shreg[7:1]};
      end
   end
   // End of a header not caused by a reset
   sequence s_end;
      $fell(us_busy) && !$past(sys_rst);
   endsequence
   property p_bit_in_frame; us_bit_valid |-> us_busy; endproperty
   a_bit_in_frame: assert property (p_bit_in_frame)
      else $error("serial bit outside a header");
   property p_first_bit; $rose(us_busy) |=> us_bit_valid; endproperty
   a_first_bit: assert property (p_first_bit)
      else $error("first bit not one cycle after busy");
   property p_whole; s_end |-> nbits[2:0] == 3'b000 && nbits >= 12'd48;
   endproperty
   a_whole: assert property (p_whole)
      else $error("header not whole octets");
   property p_ext_len; s_end |-> nbits == 12'd48 + ext_bits; endproperty
   a_ext_len: assert property (p_ext_len)
      else $error("header length disagrees with flag");
   property p_ext_max; s_end |-> !ctl_q[0] || parm_q <= 8'hf0; endproperty
   a_ext_max: assert property (p_ext_max)
      else $error("extension longer than allowed");
   property p_no_stuff; s_end |-> ctl_q[7:1] != 7'h7f; endproperty
   a_no_stuff: assert property (p_no_stuff)
      else $error("stuff pattern sent as control");
   property p_busy_end; $fell(us_bit_valid) |-> ##[0:1] !us_busy; endproperty
   a_busy_end: assert property (p_busy_end)
      else $error("gap inside a header");
   property p_echo;
      rx_payload_valid |-> $past(ds_octet_valid) && rx_payload == $past(ds_octet);
   endproperty
   a_echo: assert property (p_echo)
      else $error("payload octet not echoed");
   c_ext: cover property (s_end and ctl_q[0]);
   c_mac: cover property (s_end and ctl_q[7:6] == 2'b11);
   c_echo: cover property (rx_payload_valid);
endmodule // cmhf_framer_monitor
bind cmhf_framer cmhf_framer_monitor cmhf_framer_monitor_i (
   .core_clk(core_clk), .sys_rst(sys_rst), .us_bit(us_bit),
   .us_bit_valid(us_bit_valid), .us_busy(us_busy), .ds_octet(ds_octet),
   .ds_octet_valid(ds_octet_valid), .rx_payload(rx_payload),
   .rx_payload_valid(rx_payload_valid));
`default_nettype wire

/* File: tb/cmhf_phy_model.sv */
// Physical and convergence side model for the header framer.
// Assumes the bench calls its tasks; shares the core clock.
`timescale 1ns/1ns
`default_nettype none
module cmhf_phy_model (
   // Clock and upstream serial input
   input wire logic core_clk,
   input wire logic us_bit,
   input wire logic us_bit_valid,
   // Frame start and downstream octets
   output logic us_frame_start,
   output logic [7:0] ds_octet,
   output logic ds_octet_valid,
   output logic ds_frame_start
);
   logic [7:0] cap[$];
   logic [7:0] sh;
   int nb = 0;
   initial begin
      us_frame_start = 1'b0;
      ds_octet = 8'h00;
      ds_octet_valid = 1'b0;
      ds_frame_start = 1'b0;
   end
   // Collect upstream octets, first bit is the least significant
   always @(posedge core_clk) begin
      if (us_bit_valid === 1'b1) begin
         sh = {us_bit, sh[7:1]};
         nb = nb + 1;
         if (nb == 8) begin
            cap.push_back(sh);
            nb = 0;
         end
      end
   end
   task clear_cap;
      cap.delete();
      nb = 0;
   endtask
   // One-cycle frame start at a burst boundary
   task start_burst;
      @(posedge core_clk);
      us_frame_start <= 1'b1;
      @(posedge core_clk);
      us_frame_start <= 1'b0;
   endtask
   // Whole octets; gap cycles show the inverse so stale data never matches
   task send(input logic [7:0] q[$], input int gap);
      foreach (q[i]) begin
         @(posedge core_clk);
         ds_octet <= q[i];
         ds_octet_valid <= 1'b1;
         ds_frame_start <= (i == 0);
         repeat (gap) begin
            @(posedge core_clk);
            ds_octet_valid <= 1'b0;
            ds_frame_start <= 1'b0;
            ds_octet <= ~q[i];
         end
      end
      @(posedge core_clk);
      ds_octet_valid <= 1'b0;
      ds_frame_start <= 1'b0;
      ds_octet <= ~ds_octet;
   endtask
endmodule // cmhf_phy_model
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the header framer over APB and both sides.
// Assumes the framer, its constants header and the side model.
`include "cmhf_consts.vh"
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   wire [31:0] prdata;
   wire pready, pslverr, us_frame_start, us_bit, us_bit_valid, us_busy;
   wire [7:0] ds_octet, rx_payload;
   wire ds_octet_valid, ds_frame_start, rx_payload_valid;
   int err_count = 0;
   int cmp_count = 0;
   int echo_n = 0;
   int r, i;
   logic [31:0] rd;
   logic er;
   logic [7:0] ctl, parm, body, ext;
   logic [15:0] len;
   logic [7:0] frm[$];
   // Rows: control, parameter, length or service id, trailing bytes
   logic [39:0] rows [0:5] = '{40'h00_00_0004_04, 40'hc4_05_3abc_00,
      40'h01_03_0005_02, 40'hf8_02_0003_03, 40'h40_00_0003_03,
      40'h81_02_0004_02};
   always #5 core_clk = ~core_clk;
   cmhf_framer cmhf_framer_i (.core_clk(core_clk), .sys_rst(sys_rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .us_frame_start(us_frame_start), .us_bit(us_bit),
      .us_bit_valid(us_bit_valid), .us_busy(us_busy), .ds_octet(ds_octet),
      .ds_octet_valid(ds_octet_valid), .ds_frame_start(ds_frame_start),
      .rx_payload(rx_payload), .rx_payload_valid(rx_payload_valid));
   cmhf_phy_model cmhf_phy_model_i (.core_clk(core_clk), .us_bit(us_bit),
      .us_bit_valid(us_bit_valid), .us_frame_start(us_frame_start),
      .ds_octet(ds_octet), .ds_octet_valid(ds_octet_valid),
      .ds_frame_start(ds_frame_start));
   // Count payload octets handed upward
   always @(posedge core_clk) begin
      if (rx_payload_valid === 1'b1) begin
         echo_n = echo_n + 1;
      end
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
         err_count = err_count + 1;
         $display("wrong value at %0t: got %h, want %h", $time, seen, exp);
      end
   endtask
   // Setup, access, then hold until pready is seen at an edge
   task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rdc(input logic [11:0] a, input logic [31:0] exp);
      xfer(a, 1'b0, 32'h0);
      check(rd, exp);
   endtask
   function automatic logic [15:0] crc8(input logic [15:0] c,
         input logic [7:0] d);
      for (int k = 7; k >= 0; k--) begin
         c = (c[15] ^ d[k]) ? {c[14:0], 1'b0} ^ `CMHF_CRC_POLY
            : {c[14:0], 1'b0};
      end
      return c;
   endfunction
   // Header of a row with its inverted check, optionally spoiled or with body
   task build(input int idx, input logic bad, input logic down);
      logic [15:0] c;
      {ctl, parm, len, body} = rows[idx];
      ext = ctl[0] ? parm : 8'h00;
      frm = '{ctl, parm, len[15:8], len[7:0]};
      for (int k = 0; k < ext; k++) frm.push_back(8'ha0 + k[7:0]);
      c = `CMHF_CRC_INIT;
      foreach (frm[k]) c = crc8(c, frm[k]);
      c = ~c;
      frm.push_back(c[15:8]);
      frm.push_back(c[7:0] ^ {7'h00, bad});
      for (int k = 0; k < (down ? body : 0); k++) frm.push_back(8'h10 + k[7:0]);
   endtask
   task complete_run;
      $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Watchdog: the run needs a few thousand cycles at most
   initial begin
      #200000;
      err_count = err_count + 1;
      complete_run;
   end
   // Main sequence
   initial begin
      repeat (6) @(posedge core_clk);
      sys_rst <= 1'b0;
      rdc(`CMHF_REG_STATUS, 32'h0000_0010);
      rdc(`CMHF_REG_COUNT, 32'h0000_0000);
      xfer(12'h024, 1'b0, 32'h0);
      check({31'h0, er}, 32'h1);
      check(rd, 32'h0);
      xfer(`CMHF_REG_CTRL, 1'b1, 32'h2);
      // Each row goes up the serial side, then down the octet side
      for (r = 0; r < 6; r++) begin
         build(r, 1'b0, 1'b0);
         xfer(`CMHF_REG_TX_HDR, 1'b1, {16'h0000, parm, ctl});
         for (i = 0; i < ext; i++) xfer(`CMHF_REG_TX_EXT, 1'b1, 32'ha0 + i);
         xfer(`CMHF_REG_TX_LEN, 1'b1, {16'h0000, len});
         cmhf_phy_model_i.clear_cap();
         xfer(`CMHF_REG_CTRL, 1'b1, 32'h13);
         cmhf_phy_model_i.start_burst();
         do begin
            @(posedge core_clk);
         end while (us_busy === 1'b1);
         check(cmhf_phy_model_i.cap.size(), frm.size());
         foreach (frm[k]) check(cmhf_phy_model_i.cap[k], frm[k]);
         build(r, 1'b0, 1'b1);
         echo_n = 0;
         cmhf_phy_model_i.send(frm, r % 2);
         repeat (3) @(posedge core_clk);
         if (ctl[7:6] == 2'b00) check(echo_n, body);
         if (^ctl[7:6]) check(echo_n, 0);
         rdc(`CMHF_REG_RX_HDR, {len, parm, ctl});
         xfer(`CMHF_REG_CTRL, 1'b1, 32'h6);
         for (i = 0; i < ext; i++) rdc(`CMHF_REG_RX_EXT, 32'ha0 + i);
      end
      rdc(`CMHF_REG_RX_TLV, 32'h0000_a002);
      // A stuff octet on the octet side is dropped, the next frame parses
      frm = '{8'hff};
      cmhf_phy_model_i.send(frm, 0);
      build(0, 1'b0, 1'b1);
      echo_n = 0;
      cmhf_phy_model_i.send(frm, 0);
      repeat (3) @(posedge core_clk);
      check(echo_n, 4);
      // A spoiled check drops the frame and raises the error flag
      build(0, 1'b1, 1'b1);
      echo_n = 0;
      cmhf_phy_model_i.send(frm, 0);
      repeat (3) @(posedge core_clk);
      check(echo_n, 0);
      xfer(`CMHF_REG_STATUS, 1'b0, 32'h0);
      check(rd & 32'h1, 32'h1);
      rdc(`CMHF_REG_COUNT, {16'h0001, 16'h0007});
      xfer(`CMHF_REG_CTRL, 1'b1, 32'ha);
      xfer(`CMHF_REG_STATUS, 1'b0, 32'h0);
      check(rd & 32'h1, 32'h0);
      // The stuff pattern as control byte is refused and nothing leaves
      xfer(`CMHF_REG_TX_HDR, 1'b1, 32'h0000_00fe);
      xfer(`CMHF_REG_CTRL, 1'b1, 32'h3);
      cmhf_phy_model_i.start_burst();
      repeat (3) @(posedge core_clk);
      check({31'h0, us_busy}, 32'h0);
      xfer(`CMHF_REG_STATUS, 1'b0, 32'h0);
      check(rd & 32'h8, 32'h8);
      complete_run;
   end
endmodule // testbench
`default_nettype wire
